//--- rtl/scg_pkg.sv
// Constants of the system clock gear controller.
// Assumes a register bus with 32-bit words and byte address = 4 x index.
package scg_pkg;
  // Register indices, byte address is index times four
  localparam logic [9:0] IDX_CTRL0 = 10'h0E0;
  localparam logic [9:0] IDX_CTRL1 = 10'h0E1;
  localparam logic [9:0] IDX_CTRL2 = 10'h0E2;
  localparam logic [9:0] IDX_DBL0 = 10'h0F8;
  localparam logic [9:0] IDX_SUPPLY = 10'h449;
  // Reset values
  localparam logic [7:0] RST_CTRL0 = 8'hE0;
  localparam logic [7:0] RST_CTRL1 = 8'h04;
  localparam logic [7:0] RST_CTRL2 = 8'h2C;
  localparam logic [7:0] RST_DBL0 = 8'h00;
  localparam logic [7:0] RST_SUPPLY = 8'h00;
  // Writable bit masks
  localparam logic [7:0] MSK_CTRL1 = 8'h0F;
  localparam logic [7:0] MSK_CTRL2 = 8'h7F;
  localparam logic [7:0] MSK_DBL0 = 8'hD0;
  localparam logic [7:0] MSK_SUPPLY = 8'h0F;
  // Control 0 fields
  localparam int HI_EN_B = 7;
  localparam int LO_EN_B = 6;
  localparam int HI_AFTER_B = 5;
  localparam int LO_AFTER_B = 4;
  localparam int AFTER_SEL_B = 3;
  localparam int WUF_B = 2;
  // Control 1 fields
  localparam int SRC_B = 3;
  localparam int GEAR_LSB = 0;
  localparam logic [2:0] GEAR_DIV16 = 3'h4;
  // Control 2 fields
  localparam int WUP_LSB = 4;
  localparam int HALT_LSB = 2;
  localparam int STANDBY_DRIVE_SELECT_B = 1;
  localparam int STANDBY_PIN_HOLD_B = 0;
  // Doubler fields
  localparam int ACT_LSB = 6;
  localparam int LOCKF_B = 5;
  localparam int LOCKT_B = 4;
  localparam logic [1:0] ACT_STOP = 2'h0;
  localparam logic [1:0] ACT_LOCKUP = 2'h1;
  // Timing counts in oscillator cycles
  localparam int WUP8_CNT = 256;
  localparam int WUP14_CNT = 16384;
  localparam int WUP16_CNT = 65536;
  localparam int LOCK12_CNT = 4096;
  localparam int LOCK10_CNT = 1024;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CFG_SINGLE = 2'b00,
    CFG_DUAL = 2'b01,
    CFG_TRIPLE = 2'b10
  } scg_cfg_t;
endpackage

//--- rtl/scg_clk_if.sv
// Carrier between the register block and the clock generator.
// Assumes both ends run on the same system clock.
interface scg_clk_if;
  logic hi_osc_pin;
  logic lo_osc_pin;
  logic src_sel;
  logic [2:0] gear;
  logic hi_rise;
  logic lo_rise;
  logic main_clk;
  logic state_clk;
  modport ctl (output hi_osc_pin, lo_osc_pin, src_sel, gear,
    input hi_rise, lo_rise, main_clk, state_clk);
  modport gen (input hi_osc_pin, lo_osc_pin, src_sel, gear,
    output hi_rise, lo_rise, main_clk, state_clk);
endinterface

//--- rtl/scg_gear.sv
// Clock gear and source switch producing main and state clock levels.
// Assumes oscillator inputs toggle slower than half the system clock.
module scg_gear (
  input wire logic i_clk,
  input wire logic i_nrst,
  scg_clk_if.gen bus
);
  typedef struct packed {
    logic [2:0] hi_s;
    logic [2:0] lo_s;
    logic act_src;
    logic [2:0] act_gear;
    logic [3:0] cnt;
    logic mclk;
    logic sclk;
    logic skip;
  } scg_gear_st_t;

  scg_gear_st_t st_r;
  scg_gear_st_t st_nxt;
  logic [3:0] lim;
  logic tick;

  always_comb begin
    st_nxt = st_r;
    st_nxt.hi_s = {st_r.hi_s[1:0], bus.hi_osc_pin};
    st_nxt.lo_s = {st_r.lo_s[1:0], bus.lo_osc_pin};
    case (st_r.act_gear)
      3'h0: lim = 4'h0;
      3'h1: lim = 4'h1;
      3'h2: lim = 4'h3;
      3'h3: lim = 4'h7;
      default: lim = 4'hF;
    endcase
    if (st_r.act_src) begin
      tick = st_r.lo_s[1] ^ st_r.lo_s[2];
    end else begin
      tick = st_r.hi_s[1] ^ st_r.hi_s[2];
    end
    if (tick && st_r.skip) begin
      // First edge of a new source may be partial
      st_nxt.skip = 1'b0;
    end else if (tick) begin
      if (st_r.act_src || st_r.cnt == lim) begin
        st_nxt.cnt = 4'h0;
        st_nxt.mclk = ~st_r.mclk;
        if (st_r.mclk) begin
          // Settings change only at a falling edge
          st_nxt.act_src = bus.src_sel;
          st_nxt.act_gear = bus.gear;
          st_nxt.skip = bus.src_sel ^ st_r.act_src;
        end else begin
          st_nxt.sclk = ~st_r.sclk;
        end
      end else begin
        st_nxt.cnt = st_r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
      st_r.act_gear <= scg_pkg::GEAR_DIV16;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.hi_rise = st_r.hi_s[1] & ~st_r.hi_s[2];
  assign bus.lo_rise = st_r.lo_s[1] & ~st_r.lo_s[2];
  assign bus.main_clk = st_r.mclk;
  assign bus.state_clk = st_r.sclk;
endmodule // scg_gear

//--- rtl/scg_top.sv
// System clock gear controller with AXI4-Lite register access.
// Assumes oscillator pins are asynchronous and stop release is a pulse.
module scg_top #(
  parameter int WUP14 = scg_pkg::WUP14_CNT,
  parameter int WUP16 = scg_pkg::WUP16_CNT
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic i_hi_osc_pin_a,
  input wire logic i_lo_osc_pin_a,
  input wire logic i_stop_release,
  output logic o_hi_osc_enable,
  output logic o_lo_osc_enable,
  output logic o_main_system_clock,
  output logic o_state_clock,
  output logic [1:0] o_clock_config,
  output logic [1:0] o_doubler_action,
  output logic [1:0] o_halt_kind,
  output logic o_standby_drive_select,
  output logic o_standby_pin_hold,
  output logic [3:0] o_supply_select
);
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] dbl0;
    logic [7:0] supply;
    logic wup_busy;
    logic [15:0] wup_cnt;
    logic lock_busy;
    logic [11:0] lock_cnt;
    logic aw_hold;
    logic [9:0] aw_idx;
    logic w_hold;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } scg_top_st_t;

  scg_top_st_t st_r;
  scg_top_st_t st_nxt;
  scg_clk_if clk_if ();
  logic wup_tick;
  logic [15:0] wup_last;
  logic [11:0] lock_last;
  logic [9:0] ridx;
  logic [7:0] wv;

  scg_gear u_gear (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .bus(clk_if.gen)
  );

  assign clk_if.hi_osc_pin = i_hi_osc_pin_a;
  assign clk_if.lo_osc_pin = i_lo_osc_pin_a;
  assign clk_if.src_sel = st_r.ctrl1[scg_pkg::SRC_B];
  assign clk_if.gear = st_r.ctrl1[scg_pkg::GEAR_LSB +: 3];

  always_comb begin
    st_nxt = st_r;
    wv = st_r.w_data;
    ridx = s_axi_araddr[11:2];
    // Warm-up counts cycles of the oscillator being brought up
    if (st_r.ctrl1[scg_pkg::SRC_B]) begin
      wup_tick = clk_if.hi_rise;
    end else begin
      wup_tick = clk_if.lo_rise;
    end
    case (st_r.ctrl2[scg_pkg::WUP_LSB +: 2])
      2'h2: wup_last = 16'(WUP14 - 1);
      2'h3: wup_last = 16'(WUP16 - 1);
      default: wup_last = 16'(scg_pkg::WUP8_CNT - 1);
    endcase
    if (st_r.dbl0[scg_pkg::LOCKT_B]) begin
      lock_last = 12'(scg_pkg::LOCK10_CNT - 1);
    end else begin
      lock_last = 12'(scg_pkg::LOCK12_CNT - 1);
    end
    if (st_r.wup_busy && wup_tick) begin
      st_nxt.wup_cnt = st_r.wup_cnt + 16'h0001;
      if (st_r.wup_cnt == wup_last) begin
        st_nxt.wup_busy = 1'b0;
      end
    end
    if (st_r.lock_busy && clk_if.hi_rise) begin
      st_nxt.lock_cnt = st_r.lock_cnt + 12'h001;
      if (st_r.lock_cnt == lock_last) begin
        st_nxt.lock_busy = 1'b0;
      end
    end
    // Release from stop restores the chosen oscillators and source
    if (i_stop_release) begin
      st_nxt.ctrl0[scg_pkg::HI_EN_B] = st_r.ctrl0[scg_pkg::HI_AFTER_B];
      st_nxt.ctrl0[scg_pkg::LO_EN_B] = st_r.ctrl0[scg_pkg::LO_AFTER_B];
      st_nxt.ctrl1[scg_pkg::SRC_B] = st_r.ctrl0[scg_pkg::AFTER_SEL_B];
    end
    // Write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_hold = 1'b1;
      st_nxt.aw_idx = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_hold = 1'b1;
      st_nxt.w_data = s_axi_wdata[7:0];
      st_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (st_r.aw_hold && st_r.w_hold) begin
      st_nxt.aw_hold = 1'b0;
      st_nxt.w_hold = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = scg_pkg::RESP_OKAY;
      if (st_r.aw_idx == scg_pkg::IDX_CTRL0) begin
        if (st_r.w_lane0) begin
          st_nxt.ctrl0 = {wv[7:3], 1'b0, wv[1:0]};
          if (wv[scg_pkg::WUF_B]) begin
            st_nxt.wup_busy = 1'b1;
            st_nxt.wup_cnt = 16'h0000;
          end
        end
      end else if (st_r.aw_idx == scg_pkg::IDX_CTRL1) begin
        if (st_r.w_lane0) begin
          st_nxt.ctrl1 = wv & scg_pkg::MSK_CTRL1;
        end
      end else if (st_r.aw_idx == scg_pkg::IDX_CTRL2) begin
        if (st_r.w_lane0) begin
          st_nxt.ctrl2 = wv & scg_pkg::MSK_CTRL2;
        end
      end else if (st_r.aw_idx == scg_pkg::IDX_DBL0) begin
        if (st_r.w_lane0) begin
          st_nxt.dbl0 = wv & scg_pkg::MSK_DBL0;
          if (wv[scg_pkg::ACT_LSB +: 2] == scg_pkg::ACT_LOCKUP &&
              st_r.dbl0[scg_pkg::ACT_LSB +: 2] == scg_pkg::ACT_STOP) begin
            st_nxt.lock_busy = 1'b1;
            st_nxt.lock_cnt = 12'h000;
          end
        end
      end else if (st_r.aw_idx == scg_pkg::IDX_SUPPLY) begin
        if (st_r.w_lane0) begin
          st_nxt.supply = wv & scg_pkg::MSK_SUPPLY;
        end
      end else begin
        st_nxt.bresp = scg_pkg::RESP_SLVERR;
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // Read channel
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = scg_pkg::RESP_OKAY;
      if (ridx == scg_pkg::IDX_CTRL0) begin
        st_nxt.rdata = st_r.ctrl0;
        st_nxt.rdata[scg_pkg::WUF_B] = st_r.wup_busy;
      end else if (ridx == scg_pkg::IDX_CTRL1) begin
        st_nxt.rdata = st_r.ctrl1;
      end else if (ridx == scg_pkg::IDX_CTRL2) begin
        st_nxt.rdata = st_r.ctrl2;
      end else if (ridx == scg_pkg::IDX_DBL0) begin
        st_nxt.rdata = st_r.dbl0;
        st_nxt.rdata[scg_pkg::LOCKF_B] = st_r.lock_busy;
      end else if (ridx == scg_pkg::IDX_SUPPLY) begin
        st_nxt.rdata = st_r.supply;
      end else begin
        st_nxt.rdata = 8'h00;
        st_nxt.rresp = scg_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
      st_r.ctrl0 <= scg_pkg::RST_CTRL0;
      st_r.ctrl1 <= scg_pkg::RST_CTRL1;
      st_r.ctrl2 <= scg_pkg::RST_CTRL2;
      st_r.dbl0 <= scg_pkg::RST_DBL0;
      st_r.supply <= scg_pkg::RST_SUPPLY;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = ~st_r.aw_hold & ~st_r.bvalid;
  assign s_axi_wready = ~st_r.w_hold & ~st_r.bvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = ~st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = {24'h000000, st_r.rdata};

  assign o_hi_osc_enable = st_r.ctrl0[scg_pkg::HI_EN_B];
  assign o_lo_osc_enable = st_r.ctrl0[scg_pkg::LO_EN_B];
  assign o_main_system_clock = clk_if.main_clk;
  assign o_state_clock = clk_if.state_clk;
  assign o_doubler_action = st_r.dbl0[scg_pkg::ACT_LSB +: 2];
  assign o_halt_kind = st_r.ctrl2[scg_pkg::HALT_LSB +: 2];
  assign o_standby_drive_select = st_r.ctrl2[scg_pkg::STANDBY_DRIVE_SELECT_B];
  assign o_standby_pin_hold = st_r.ctrl2[scg_pkg::STANDBY_PIN_HOLD_B];
  assign o_supply_select = st_r.supply[3:0];

  // Configuration seen from the doubler action and the low oscillator enable
  always_comb begin
    if (st_r.dbl0[scg_pkg::ACT_LSB +: 2] != scg_pkg::ACT_STOP) begin
      o_clock_config = scg_pkg::CFG_TRIPLE;
    end else if (st_r.ctrl0[scg_pkg::LO_EN_B]) begin
      o_clock_config = scg_pkg::CFG_DUAL;
    end else begin
      o_clock_config = scg_pkg::CFG_SINGLE;
    end
  end
endmodule // scg_top

//--- tb/scg_properties.sv
// Checker of the bus answers and clock outputs of scg_top.
// Assumes the bind below; sees only the top ports.
module scg_properties (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bready,
  input wire logic o_main_system_clock,
  input wire logic o_state_clock,
  input wire logic [1:0] o_clock_config
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_next;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  write_answer_a: assert property (both_taken |=> resp_next) else $error("late bvalid");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late rvalid");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h000
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
  state_half_a: assert property ($changed(o_state_clock) |-> $rose(o_main_system_clock))
    else $error("state clock");
  no_short_a: assert property ($changed(o_main_system_clock) |=>
    $stable(o_main_system_clock) [*2]) else $error("short pulse");
  config_legal_a: assert property (o_clock_config != 2'b11) else $error("config");
endmodule // scg_properties

bind scg_top scg_properties i_props (.*);

//--- tb/system_clock_gear_controller_bench.sv
// Bench of the clock controller: bus tasks, register and clock checks.
// Assumes scg_top with short warm-up counts.
module system_clock_gear_controller_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, i_stop_release;
  logic i_hi_osc_pin_a = 1'b0;
  logic i_lo_osc_pin_a = 1'b0;
  logic o_hi_osc_enable, o_lo_osc_enable, o_main_system_clock, o_state_clock;
  logic o_standby_drive_select, o_standby_pin_hold;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, o_supply_select;
  logic [1:0] s_axi_bresp, s_axi_rresp, o_clock_config, o_doubler_action, o_halt_kind, rs;
  int n_errors, checks_done;
  int cnt = 0;
  localparam logic [9:0] C0 = scg_pkg::IDX_CTRL0;
  localparam logic [9:0] C1 = scg_pkg::IDX_CTRL1;
  localparam logic [9:0] DB = scg_pkg::IDX_DBL0;
  scg_top #(.WUP14(4), .WUP16(8)) i_dut (.*);
  initial begin
    i_clk = 0;
    forever #25 i_clk = ~i_clk;
  end
  // Fast pin period 6 cycles, slow pin period 8 cycles
  always @(posedge i_clk) begin
    cnt <= cnt + 1;
    if (cnt % 3 == 2) i_hi_osc_pin_a <= ~i_hi_osc_pin_a;
    if (cnt % 4 == 3) i_lo_osc_pin_a <= ~i_lo_osc_pin_a;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic axw(input logic [9:0] ix, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, pa, pw;
    ta = 0;
    tw = 0;
    @(posedge i_clk);
    s_axi_awaddr <= {ix, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge i_clk);
      pa = s_axi_awvalid && s_axi_awready;
      pw = s_axi_wvalid && s_axi_wready;
      @(posedge i_clk);
      ta |= pa;
      tw |= pw;
      if (pa) s_axi_awvalid <= 1'b0;
      if (pw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge i_clk); while (!s_axi_bvalid);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge i_clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [9:0] ix);
    @(posedge i_clk);
    s_axi_araddr <= {ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge i_clk); while (!s_axi_arready);
    @(posedge i_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge i_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge i_clk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [9:0] ix, input logic [7:0] e);
    axr(ix);
    chk("rdata", {24'h0, e}, rd);
    chk("rresp", 32'h0, {30'h0, rs});
  endtask
  task automatic mper(input int e);
    time t;
    repeat (2) @(posedge o_main_system_clock);
    t = $time;
    @(posedge o_main_system_clock);
    chk("period", 32'(e), 32'(($time - t) / 50));
  endtask
  task automatic sper(input int e);
    time t;
    repeat (2) @(posedge o_state_clock);
    t = $time;
    @(posedge o_state_clock);
    chk("state period", 32'(e), 32'(($time - t) / 50));
  endtask
  task automatic stop_pulse;
    @(posedge i_clk);
    i_stop_release <= 1'b1;
    @(posedge i_clk);
    i_stop_release <= 1'b0;
    @(negedge i_clk);
  endtask
  task automatic close_out;
    if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #2000000;
    n_errors++;
    close_out();
  end
  initial begin
    {i_nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {i_stop_release, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {n_errors, checks_done} = '0;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    rchk(C0, scg_pkg::RST_CTRL0);
    rchk(C1, 8'h04);
    rchk(scg_pkg::IDX_CTRL2, scg_pkg::RST_CTRL2);
    rchk(DB, scg_pkg::RST_DBL0);
    rchk(scg_pkg::IDX_SUPPLY, scg_pkg::RST_SUPPLY);
    chk("config", 32'h1, {30'h0, o_clock_config});
    chk("hi enable", 32'h1, {31'h0, o_hi_osc_enable});
    chk("halt", 32'h3, {30'h0, o_halt_kind});
    mper(96);
    sper(192);
    axr(10'h000);
    chk("rresp", 32'h2, {30'h0, rs});
    axw(10'h000, 8'hFF, 2'h2);
    for (int g = 0; g < 5; g++) begin
      axw(C1, 8'(g), 2'h0);
      rchk(C1, 8'(g));
      mper(6 << g);
    end
    axw(C1, 8'hF8, 2'h0);
    rchk(C1, 8'h08);
    mper(8);
    s_axi_wstrb <= 4'h0;
    axw(C1, 8'h01, 2'h0);
    rchk(C1, 8'h08);
    s_axi_wstrb <= 4'hF;
    axw(C0, 8'hE8, 2'h0);
    stop_pulse();
    chk("lo enable", 32'h0, {31'h0, o_lo_osc_enable});
    rchk(C1, 8'h08);
    axw(C0, 8'hF0, 2'h0);
    stop_pulse();
    chk("lo enable", 32'h1, {31'h0, o_lo_osc_enable});
    rchk(C1, 8'h00);
    axw(scg_pkg::IDX_CTRL2, 8'h87, 2'h0);
    rchk(scg_pkg::IDX_CTRL2, 8'h07);
    chk("halt", 32'h1, {30'h0, o_halt_kind});
    chk("drive sel", 32'h1, {31'h0, o_standby_drive_select});
    chk("pin hold", 32'h1, {31'h0, o_standby_pin_hold});
    axw(scg_pkg::IDX_SUPPLY, 8'hFF, 2'h0);
    rchk(scg_pkg::IDX_SUPPLY, 8'h0F);
    chk("supply", 32'hF, {28'h0, o_supply_select});
    for (int c = 1; c < 4; c++) begin
      axw(scg_pkg::IDX_CTRL2, 8'(c << 4), 2'h0);
      axw(C0, 8'hE4, 2'h0);
      axr(C0);
      chk("warm run", 32'h1, {31'h0, rd[2]});
      repeat ((c == 1 ? 256 : c == 2 ? 4 : 8) * 8 + 40) @(posedge i_clk);
      axr(C0);
      chk("warm end", 32'h0, {31'h0, rd[2]});
    end
    axw(DB, 8'h40, 2'h0);
    chk("action", 32'h1, {30'h0, o_doubler_action});
    rchk(DB, 8'h60);
    chk("config", 32'h2, {30'h0, o_clock_config});
    axw(DB, 8'h00, 2'h0);
    axw(C0, 8'hA0, 2'h0);
    chk("config", 32'h0, {30'h0, o_clock_config});
    close_out();
  end
endmodule // system_clock_gear_controller_bench
